/* core/pcls_cfg_ports.sv */
// Link control and status sideband ports with an APB register view
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "pcls_defines.svh"

module pcls_cfg_ports
#(
  parameter bit IS_ROOT_PORT = 1'b1
)
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  // Layer events and link state machine
  input  wire pcls_pkg::pcls_event_type     events,
  input  wire pcls_pkg::pcls_ltssm_obs_type ltssm_obs,
  output var  pcls_pkg::pcls_ltssm_req_type ltssm_req,
  // Sideband outputs to user logic
  output var  pcls_pkg::pcls_link_ctl_type  link_ctl,
  output var  logic                        nonfatal_err_seen,
  output var  logic                        unsupported_req_seen,
  output var  logic                        auto_bw_changed,
  output var  logic                        retrain_pulse,
  // Interrupt
  output var  logic                        irq
);
  import pcls_pkg::*;

  // Stored registers
  logic [15:0]               link_control_reg;
  logic [15:0]               device_status_reg;
  logic [15:0]               link_status_reg;
  logic [`PCLS_EV_COUNT-1:0] irq_status;
  logic [`PCLS_EV_COUNT-1:0] irq_enable;

  // Bus phase decode
  wire logic setup_phase = psel & ~penable;
  wire logic wr_commit   = psel & penable & pready & pwrite;
  wire logic sel_lc      = (paddr == `PCLS_OFS_LINK_CTRL);
  wire logic sel_ds      = (paddr == `PCLS_OFS_DEV_STATUS);
  wire logic sel_ls      = (paddr == `PCLS_OFS_LINK_STATUS);
  wire logic sel_is      = (paddr == `PCLS_OFS_IRQ_STATUS);
  wire logic sel_ic      = (paddr == `PCLS_OFS_IRQ_CLEAR);
  wire logic sel_ie      = (paddr == `PCLS_OFS_IRQ_ENABLE);
  wire logic mapped      = sel_lc | sel_ds | sel_ls | sel_is | sel_ic | sel_ie;

  // Write strobes, only on the completing access edge
  wire logic wr_lc = wr_commit & sel_lc;
  wire logic wr_ds = wr_commit & sel_ds;
  wire logic wr_ls = wr_commit & sel_ls;
  wire logic wr_ic = wr_commit & sel_ic;
  wire logic wr_ie = wr_commit & sel_ie;

  // Retrain is a command bit: it is never stored, so reads return zero
  wire logic retrain_req = wr_lc & pwdata[`PCLS_LC_RETRAIN]
                           & IS_ROOT_PORT;          // see [R12]

  // Link control keeps only writable fields; unused power codes pass as is
  wire logic [15:0] next_link_control =
    wr_lc ? (pwdata[15:0] & `PCLS_LC_WMASK) : link_control_reg;

  // Autonomous change qualifier
  wire logic auto_bw_event =
    (events.speed_width_chg & ~events.passed_link_down
     & ~events.chg_for_reliability)
    | (events.downstream_chg & events.downstream_autonomous); // see [R13]

  // Error detection ignores the reporting enables entirely
  wire logic nonfatal_event = events.nonfatal_err;   // see [R1]
  wire logic unsupp_event   = events.unsupp_req;     // see [R2]

  // Write-one-to-clear with the set winning over a same-cycle clear
  wire logic next_ds_nonfatal = nonfatal_event
    | (device_status_reg[`PCLS_DS_NONFATAL]
       & ~(wr_ds & pwdata[`PCLS_DS_NONFATAL]));     // see [R1]
  wire logic next_ds_unsupp = unsupp_event
    | (device_status_reg[`PCLS_DS_UNSUPP]
       & ~(wr_ds & pwdata[`PCLS_DS_UNSUPP]));       // see [R2]
  wire logic next_ls_auto_bw = auto_bw_event
    | (link_status_reg[`PCLS_LS_AUTO_BW]
       & ~(wr_ls & pwdata[`PCLS_LS_AUTO_BW]));      // see [R13]

  // Interrupt event vector in status layout
  wire logic [`PCLS_EV_COUNT-1:0] irq_events =
    {auto_bw_event, unsupp_event, nonfatal_event};
  wire logic [`PCLS_EV_COUNT-1:0] irq_clear =
    wr_ic ? pwdata[`PCLS_EV_COUNT-1:0] : '0;
  logic      [`PCLS_EV_COUNT-1:0] next_irq_status;

  // Sticky interrupt bits, one per event
  genvar gi;
  generate
    for (gi = 0; gi < `PCLS_EV_COUNT; gi++)
    begin : g_irq
      assign next_irq_status[gi] =
        irq_events[gi] | (irq_status[gi] & ~irq_clear[gi]);
    end
  endgenerate

  // Read data multiplexer
  wire logic [31:0] read_mux =
      sel_lc ? {16'h0000, link_control_reg}        // see [R12]
    : sel_ds ? {16'h0000, device_status_reg}
    : sel_ls ? {16'h0000, link_status_reg}
    : sel_is ? {{(32-`PCLS_EV_COUNT){1'b0}}, irq_status}
    : sel_ie ? {{(32-`PCLS_EV_COUNT){1'b0}}, irq_enable}
    : 32'h0000_0000;                               // clear reads zero

  // Link state machine steering from the stored control
  wire logic lc_ext_sync   = link_control_reg[`PCLS_LC_EXT_SYNC];
  wire logic lc_auto_width = link_control_reg[`PCLS_LC_AUTO_WIDTH];
  wire logic lc_link_off   = link_control_reg[`PCLS_LC_LINK_OFF];

  wire logic next_extra_os = lc_ext_sync
    & (ltssm_obs.exiting_l0s | ltssm_obs.in_recovery); // see [R8]
  wire logic next_width_grant = ltssm_obs.width_chg_req
    & (~lc_auto_width | ltssm_obs.width_chg_reliability); // see [R9]

  // Bus answer: no wait states, data latched in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_phase;
      if (setup_phase)
      begin
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // Control register and the retrain command
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_control_reg <= `PCLS_LC_RESET;
      retrain_pulse    <= 1'b0;
    end
    else
    begin
      link_control_reg <= next_link_control;
      retrain_pulse    <= retrain_req;             // see [R12] [R14]
    end
  end

  // Status registers, reserved bits stay zero
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      device_status_reg <= 16'h0000;
      link_status_reg   <= 16'h0000;
    end
    else
    begin
      device_status_reg[`PCLS_DS_NONFATAL] <= next_ds_nonfatal;
      device_status_reg[`PCLS_DS_UNSUPP]   <= next_ds_unsupp;
      link_status_reg[`PCLS_LS_AUTO_BW]    <= next_ls_auto_bw;
    end
  end

  // Interrupt status, enable and the level output
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_status <= '0;
      irq_enable <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_ie)
        irq_enable <= pwdata[`PCLS_EV_COUNT-1:0];
      irq <= |(irq_status & irq_enable);
    end
  end

  // Requests towards the link state machine
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ltssm_req <= '0;
    else
    begin
      ltssm_req.enter_recovery     <= retrain_req;      // see [R12]
      ltssm_req.enter_disabled     <= lc_link_off;      // see [R10]
      ltssm_req.extra_ordered_sets <= next_extra_os;    // see [R8]
      ltssm_req.width_chg_grant    <= next_width_grant; // see [R9]
    end
  end

  // Sideband mirrors: registered copies that hold until the field moves.
  // One cycle behind the register, which keeps every output on a flop.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_ctl             <= '0;
      nonfatal_err_seen    <= 1'b0;
      unsupported_req_seen <= 1'b0;
      auto_bw_changed      <= 1'b0;
    end
    else
    begin
      link_ctl.link_power_state_ctl <=
        link_control_reg[`PCLS_LC_PSC_HI:`PCLS_LC_PSC_LO]; // see [R3]
      link_ctl.auto_bw_irq_en <=
        link_control_reg[`PCLS_LC_AUTO_BW_IRQ];            // see [R4]
      link_ctl.bw_mgmt_irq_en <=
        link_control_reg[`PCLS_LC_BW_MGMT_IRQ];            // see [R5]
      link_ctl.clock_pm_en <=
        link_control_reg[`PCLS_LC_CLOCK_PM];               // see [R6]
      link_ctl.shared_refclk_cfg <=
        link_control_reg[`PCLS_LC_SHARED_CLK];             // see [R7]
      link_ctl.extended_sync_en <= lc_ext_sync;            // see [R14]
      link_ctl.auto_width_disable <= lc_auto_width;
      link_ctl.link_off <= lc_link_off;
      link_ctl.read_cpl_boundary <=
        link_control_reg[`PCLS_LC_CPL_BOUND];              // see [R11]
      nonfatal_err_seen    <= device_status_reg[`PCLS_DS_NONFATAL];
      unsupported_req_seen <= device_status_reg[`PCLS_DS_UNSUPP];
      auto_bw_changed      <= link_status_reg[`PCLS_LS_AUTO_BW];
    end
  end

endmodule
`default_nettype wire

/* include/pcls_defines.svh */
// Register map, field positions and reset values of the link status ports
// Function
// [R1] The non-fatal-error-detected output is set by any non-fatal error, whatever the reporting enables say.
// [R2] The unsupported-request-detected output is set by any received unsupported request, whatever the enables say.
// [R3] The two-bit power state control field is presented from link control bits 1:0 (00 off, 01 L0s entry).
// [R4] The autonomous bandwidth interrupt enable is mirrored from bit 11 and the block does not act on it.
// [R5] The bandwidth management interrupt enable is mirrored from bit 10 and the block does not act on it.
// [R6] The clock power management enable is mirrored from bit 8; clock request handling lives outside.
// [R7] Bit 6 is presented as the shared reference clock setting of both link ends.
// [R8] With extended sync set, extra ordered sets are forced on L0s exit and while in Recovery.
// [R9] With auto width disable set, width may change only to fix an unreliable link.
// [R10] With link disable set, the link state machine is steered into Disabled.
// [R11] Bit 3 gives the read completion boundary, 0 for 64 bytes and 1 for 128 bytes.
// [R12] A root port write of 1 to bit 5 starts retraining, pulses the retrain output once, and reads 0.
// [R13] Status bit 15 sets on autonomous speed or width changes that are not for reliability.
// [R14] Mirrored outputs hold until their field changes; only the retrain output is a one-cycle pulse.
`ifndef PCLS_DEFINES_SVH
`define PCLS_DEFINES_SVH

// Byte offsets on the register bus
`define PCLS_OFS_LINK_CTRL   12'h000
`define PCLS_OFS_DEV_STATUS  12'h004
`define PCLS_OFS_LINK_STATUS 12'h008
`define PCLS_OFS_IRQ_STATUS  12'h00C
`define PCLS_OFS_IRQ_CLEAR   12'h010
`define PCLS_OFS_IRQ_ENABLE  12'h014

// Link control fields
`define PCLS_LC_PSC_LO       0
`define PCLS_LC_PSC_HI       1
`define PCLS_LC_CPL_BOUND    3
`define PCLS_LC_LINK_OFF     4
`define PCLS_LC_RETRAIN      5
`define PCLS_LC_SHARED_CLK   6
`define PCLS_LC_EXT_SYNC     7
`define PCLS_LC_CLOCK_PM     8
`define PCLS_LC_AUTO_WIDTH   9
`define PCLS_LC_BW_MGMT_IRQ  10
`define PCLS_LC_AUTO_BW_IRQ  11
`define PCLS_LC_WMASK        16'h0FDB
`define PCLS_LC_RESET        16'h0000

// Status fields
`define PCLS_DS_NONFATAL     1
`define PCLS_DS_UNSUPP       3
`define PCLS_LS_AUTO_BW      15

// Interrupt event bits
`define PCLS_EV_NONFATAL     0
`define PCLS_EV_UNSUPP       1
`define PCLS_EV_AUTO_BW      2
`define PCLS_EV_COUNT        3

`endif

/* include/pcls_pkg.sv */
// Types shared by the link status port block
package pcls_pkg;

  // Mirrored link control fields towards user logic
  typedef struct packed {
    logic [1:0] link_power_state_ctl;
    logic       auto_bw_irq_en;
    logic       bw_mgmt_irq_en;
    logic       clock_pm_en;
    logic       shared_refclk_cfg;
    logic       extended_sync_en;
    logic       auto_width_disable;
    logic       link_off;
    logic       read_cpl_boundary;
  } pcls_link_ctl_type;

  // Events reported by the transaction and physical layers
  typedef struct packed {
    logic nonfatal_err;
    logic unsupp_req;
    logic speed_width_chg;
    logic chg_for_reliability;
    logic passed_link_down;
    logic downstream_chg;
    logic downstream_autonomous;
  } pcls_event_type;

  // Link state machine observations
  typedef struct packed {
    logic exiting_l0s;
    logic in_recovery;
    logic width_chg_req;
    logic width_chg_reliability;
  } pcls_ltssm_obs_type;

  // Requests towards the link state machine
  typedef struct packed {
    logic enter_recovery;
    logic enter_disabled;
    logic extra_ordered_sets;
    logic width_chg_grant;
  } pcls_ltssm_req_type;

endpackage

/* testbench/pcls_cfg_ports_chk.sv */
// Concurrent checks on the link status port block
`timescale 1ns/1ns
`default_nettype none
module pcls_chk
#(
  parameter bit IS_ROOT_PORT = 1'b1
)
(
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         rst_b,
  // APB request side
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  // Link side
  input wire pcls_pkg::pcls_event_type     events,
  input wire pcls_pkg::pcls_ltssm_obs_type ltssm_obs,
  input wire pcls_pkg::pcls_ltssm_req_type ltssm_req,
  // User side
  input wire pcls_pkg::pcls_link_ctl_type  link_ctl,
  input wire logic                         nonfatal_err_seen,
  input wire logic                         unsupported_req_seen,
  input wire logic                         auto_bw_changed,
  input wire logic                         retrain_pulse
);
  import pcls_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Link control commit and the field mirror it must produce
  wire       wr_lc = psel && penable && pready && pwrite && paddr == 12'h000;
  wire       rt_wr = wr_lc && pwdata[5] && IS_ROOT_PORT;
  wire [9:0] lc_exp = {pwdata[1:0], pwdata[11:10], pwdata[8], pwdata[6],
                       pwdata[7], pwdata[9], pwdata[4:3]};
  retrain_start_a: assert property (
    rt_wr |=> retrain_pulse && ltssm_req.enter_recovery)
    else $error("retrain not started");
  retrain_once_a: assert property (
    retrain_pulse |-> $past(rt_wr) ##1 !retrain_pulse)
    else $error("retrain pulse wrong");
  lc_mirror_a: assert property (
    wr_lc |-> ##2 link_ctl == $past(lc_exp, 2))
    else $error("link control mirror wrong");
  lc_hold_a: assert property (
    $changed(link_ctl) |-> $past(wr_lc, 2))
    else $error("link control changed unasked");
  // The disable request leaves the stored field together with the mirror
  link_off_a: assert property (
    wr_lc |-> ##2 ltssm_req.enter_disabled == $past(pwdata[4], 2))
    else $error("disable request not following link off");
  ext_sync_a: assert property (
    ltssm_req.extra_ordered_sets == (link_ctl.extended_sync_en
      && $past(ltssm_obs.exiting_l0s || ltssm_obs.in_recovery)))
    else $error("extra ordered sets wrong");
  // The grant flop was still in reset one edge back, hence the reset term
  width_grant_a: assert property (
    ltssm_req.width_chg_grant == ($past(rst_b)
      && $past(ltssm_obs.width_chg_req)
      && (!link_ctl.auto_width_disable
          || $past(ltssm_obs.width_chg_reliability))))
    else $error("width change grant wrong");
  nonfatal_a: assert property (
    events.nonfatal_err |-> ##2 nonfatal_err_seen)
    else $error("nonfatal error not shown");
  unsupp_a: assert property (
    events.unsupp_req |-> ##2 unsupported_req_seen)
    else $error("unsupported request not shown");
  auto_bw_a: assert property (
    events.speed_width_chg && !events.passed_link_down
      && !events.chg_for_reliability |-> ##2 auto_bw_changed)
    else $error("autonomous change not shown");
endmodule
bind pcls_cfg_ports pcls_chk #(.IS_ROOT_PORT(IS_ROOT_PORT)) chk (
  .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .events, .ltssm_obs, .ltssm_req, .link_ctl, .nonfatal_err_seen,
  .unsupported_req_seen, .auto_bw_changed, .retrain_pulse);
`default_nettype wire

/* testbench/pcls_user.sv */
// Model of the user logic beside the link status port block
`timescale 1ns/1ns
`default_nettype none
module pcls_user
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  // Sideband from the block
  input  wire pcls_pkg::pcls_link_ctl_type link_ctl,
  input  wire logic                        auto_bw_changed,
  // Bandwidth management status kept by user logic
  input  wire logic                        bw_mgmt_status,
  // What user logic builds itself
  output var  logic                        user_irq,
  output var  logic                        clkreq_ok,
  output var  logic                        bw_irq
);
  import pcls_pkg::*;
  // The block only mirrors the enables, so the interrupts are made here
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      user_irq <= 1'b0;
      bw_irq   <= 1'b0;
    end
    else
    begin
      user_irq <= link_ctl.auto_bw_irq_en && auto_bw_changed;
      bw_irq   <= link_ctl.bw_mgmt_irq_en && bw_mgmt_status;
    end
  // Clock request use only while clock power management is on
  assign clkreq_ok = link_ctl.clock_pm_en;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the link status port block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("wrong value at %0t: %h not %h", $time, g, e); \
    end \
  end
module tb_top;
  import pcls_pkg::*;
  // Stimulus
  logic               ref_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  pcls_event_type     events = '0;
  pcls_ltssm_obs_type ltssm_obs = '0;
  logic               bw_mgmt_status = 1'b0;
  // Observed outputs and bookkeeping
  logic [31:0]        prdata;
  logic               pready, pslverr, irq, retrain_pulse, auto_bw_changed;
  logic               nonfatal_err_seen, unsupported_req_seen;
  logic               user_irq, clkreq_ok, bw_irq;
  pcls_ltssm_req_type ltssm_req;
  pcls_link_ctl_type  link_ctl;
  logic [32:0]        exp_q[$];
  logic [32:0]        note;
  int                 err_count = 0;
  int                 compares = 0;
  int                 retrains = 0;
  pcls_cfg_ports uut (
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .events, .ltssm_obs, .ltssm_req, .link_ctl,
    .nonfatal_err_seen, .unsupported_req_seen, .auto_bw_changed,
    .retrain_pulse, .irq);
  pcls_user partner (.ref_clk, .rst_b, .link_ctl, .auto_bw_changed,
    .bw_mgmt_status, .user_irq, .clkreq_ok, .bw_irq);
  // Retrain pulses seen, later held against the writes that asked for them
  always @(posedge ref_clk)
    if (retrain_pulse === 1'b1)
      retrains++;
  // Clock, and link state observations that wander freely
  initial
    forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    ltssm_obs <= pcls_ltssm_obs_type'(4'($urandom));
  // Each finished transfer is compared with the oldest note
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1)
    begin
      note = exp_q.pop_front();
      `CHK({pslverr, prdata}, note)
    end
  // One APB transfer; the expected answer is noted first
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    int n;
    exp_q.push_back(x);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      test_done();
    end
  endtask
  // One-cycle event pulse from the layers
  task automatic pulse(input pcls_event_type v);
    @(posedge ref_clk);
    events <= v;
    @(posedge ref_clk);
    events <= '0;
  endtask
  task automatic test_done;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [31:0]    d;
    static pcls_event_type ev[5] = '{7'h18, 7'h14, 7'h02, 7'h10, 7'h03};
    static int      rt_exp = 0;
    void'($urandom(32'h22EC));
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place refused both ways
    for (int a = 0; a < 24; a += 4)
      apb(1'b0, 12'(a), 32'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h020, 32'hFFFF, {1'b1, 32'h0});
    $display("test reset done");
    // Every power state code, then all ones with retrain and reserved bits
    for (int i = 0; i < 5; i++)
    begin
      d = (i == 4) ? 32'hFFFF_FFFF : {30'($urandom), 2'(i)};
      apb(1'b1, 12'h000, d, 33'h0);
      rt_exp += int'(d[5]);
      apb(1'b0, 12'h000, 32'h0, {17'h0, d[15:0] & 16'h0FDB});
      `CHK(link_ctl, {d[1:0], d[11:10], d[8], d[6], d[7], d[9], d[4:3]})
      `CHK(ltssm_req.enter_disabled, d[4])
      `CHK(clkreq_ok, d[8])
    end
    `CHK(retrains, rt_exp)
    $display("test link control done");
    // All ones left the management enable set; user logic raises its irq
    bw_mgmt_status <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(bw_irq, 1'b1)
    bw_mgmt_status <= 1'b0;
    // Only autonomous, non-reliability changes set the status bit
    for (int i = 0; i < 5; i++)
    begin
      pulse(ev[i]);
      apb(1'b0, 12'h008, 32'h0, {1'b0, 32'(i > 2) << 15});
      `CHK(user_irq, i > 2)
      apb(1'b1, 12'h008, 32'h8000, 33'h0);
    end
    $display("test bandwidth status done");
    // Errors stay set; irq follows enable and clear, not the status
    apb(1'b1, 12'h010, 32'h7, 33'h0);
    pulse(7'h60);
    repeat (3) @(posedge ref_clk);
    `CHK({nonfatal_err_seen, unsupported_req_seen, irq}, 3'b110)
    apb(1'b1, 12'h014, 32'h3, 33'h0);
    apb(1'b0, 12'h00C, 32'h0, 33'h3);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h010, 32'h3, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'hA);
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h004, 32'hA, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h0);
    `CHK({nonfatal_err_seen, unsupported_req_seen}, 2'b00)
    $display("test error status done");
    test_done();
  end
endmodule
`default_nettype wire
